// file: design/gp_timer_map.svh
// Constants of the general-purpose timer unit
`ifndef GP_TIMER_MAP_SVH
`define GP_TIMER_MAP_SVH
`define GPT_CFG_32_PERIODIC 3'h0
`define GPT_CFG_32_CLOCK 3'h1
`define GPT_MODE_ONE_SHOT 2'h1
`define GPT_MODE_PERIODIC 2'h2
`define GPT_HALF_RESET 16'hFFFF
`define GPT_PRESCALE_RESET 8'h00
`define GPT_CLOCK_MODE_START 32'h0000_0001
`define GPT_MATCH_RESET 32'hFFFF_FFFF
`define GPT_RTC_IN_HZ 32768
`define GPT_RTC_OUT_HZ 1
`define GPT_RTC_DIVIDE (`GPT_RTC_IN_HZ / `GPT_RTC_OUT_HZ)
`endif

// file: design/gp_timer_pkg.sv
// Types of the general-purpose timer unit
package gp_timer_pkg;
    typedef struct packed {
        logic low_enable_bit;
        logic low_debug_stall_bit;
        logic high_debug_stall_bit;
        logic low_adc_trigger_enable;
        logic clock_mode_enable_bit;
    } timer_control_t;

    typedef struct packed {
        logic clock_match_raw_flag;
        logic timeout_raw_flag;
    } irq_flags_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DOWN = 3'b010,
        ST_CLOCK = 3'b100
    } run_state_t;
endpackage

// file: design/edge_sync.sv
// Three-stage synchroniser with rising-edge pulse for the capture/compare pin
module edge_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pin and event
    input wire logic pin,
    output logic rise
);
    logic s1;
    logic s2;
    logic s3;
    logic rise_lvl;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A new level counts once stages two and three agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rise <= 1'b0;
        end else begin
            rise <= s2 & s3 & ~rise_lvl;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rise_lvl <= 1'b0;
        end else if (s2 == s3) begin
            rise_lvl <= s3;
        end
    end
endmodule // edge_sync

// file: design/gp_timer_unit.sv
// General-purpose timer unit in its 32-bit modes
`include "gp_timer_map.svh"

module gp_timer_unit
    import gp_timer_pkg::*;
#(
    parameter int RTC_DIVIDE = `GPT_RTC_DIVIDE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Configuration
    input wire logic [2:0] timer_config_reg,
    input wire logic [1:0] low_mode_field,
    input wire logic [1:0] high_mode_field,
    // Control writes
    input wire logic ctl_write,
    input wire timer_control_t ctl_wdata,
    // Interval load and match writes
    input wire logic load_write,
    input wire logic [31:0] load_wdata,
    input wire logic match_write,
    input wire logic [31:0] match_wdata,
    // Prescale writes
    input wire logic low_prescale_write,
    input wire logic high_prescale_write,
    input wire logic [7:0] prescale_wdata,
    // Interrupt mask and clear
    input wire irq_flags_t irq_mask_reg,
    input wire irq_flags_t irq_clear_reg,
    // Debug halt and trigger chain
    input wire logic debug_halt,
    input wire logic adc_trigger_in,
    // Capture/compare pin
    input wire logic capture_compare_pin,
    // Status
    output timer_control_t timer_control_reg,
    output logic [31:0] low_count_value,
    output logic [31:0] load_value,
    output logic [31:0] match_value,
    output logic [7:0] low_prescale_reg,
    output logic [7:0] high_prescale_reg,
    output irq_flags_t raw_irq_status_reg,
    output irq_flags_t masked_irq_status_reg,
    output logic timer_irq,
    output logic adc_trigger_out
);
    // A divider below two could never space the ticks apart from the pin edges
    if (RTC_DIVIDE < 2) begin : g_divide_check
        $error("RTC_DIVIDE must be at least 2");
    end

    localparam int DW = $clog2(RTC_DIVIDE);

    logic [15:0] low_half;
    logic [15:0] high_half;
    logic [15:0] low_interval_load;
    logic [15:0] high_interval_load;
    logic [31:0] low_match_reg;
    logic [DW-1:0] divider;
    logic clock_seeded;
    logic pin_rise;
    logic second_tick;
    logic zero_hit;
    logic clock_hit;
    logic count_go;
    logic joined_down;
    logic joined_clock;
    logic pending_reload;
    run_state_t state;
    run_state_t next_state;

    function automatic logic [31:0] join_halves(input logic [15:0] hi, input logic [15:0] lo);
        join_halves = {hi, lo};
    endfunction

    wire [31:0] joined_count = join_halves(high_half, low_half);
    wire [31:0] joined_load = join_halves(high_interval_load, low_interval_load);

    edge_sync u_pin_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin(capture_compare_pin),
        .rise(pin_rise)
    );

    // Mode decode and the events that the counter reacts to
    always_comb begin
        joined_down = (timer_config_reg == `GPT_CFG_32_PERIODIC);
        joined_clock = (timer_config_reg == `GPT_CFG_32_CLOCK);
        count_go = timer_control_reg.low_enable_bit &
            (!debug_halt || !timer_control_reg.low_debug_stall_bit ||
             timer_control_reg.clock_mode_enable_bit);
        zero_hit = (state == ST_DOWN) && count_go && !pending_reload && (joined_count == 32'h0000_0000);
        clock_hit = (state == ST_CLOCK) && second_tick && (joined_count == low_match_reg);
    end

    // Divide the 32.768 kHz edges down to a one-second tick
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divider <= '0;
            second_tick <= 1'b0;
        end else begin
            second_tick <= 1'b0;
            if (!joined_clock || !timer_control_reg.low_enable_bit) begin
                divider <= '0;
            end else if (pin_rise) begin
                if (divider == DW'(RTC_DIVIDE - 1)) begin
                    divider <= '0;
                    second_tick <= 1'b1;
                end else begin
                    divider <= divider + DW'(1);
                end
            end
        end
    end

    // Leaving the selected mode or clearing enable always returns to idle
    always_comb begin
        case (state)
            ST_IDLE: begin
                if (joined_down && timer_control_reg.low_enable_bit) begin
                    next_state = ST_DOWN;
                end else if (joined_clock && timer_control_reg.low_enable_bit) begin
                    next_state = ST_CLOCK;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_DOWN: begin
                if (!joined_down || !timer_control_reg.low_enable_bit) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_DOWN;
                end
            end
            ST_CLOCK: begin
                if (!joined_clock || !timer_control_reg.low_enable_bit) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_CLOCK;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State follows enable one cycle later, so counting starts on the next edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Control register: software writes, one-shot expiry clears enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_control_reg <= '0;
        end else if (zero_hit && low_mode_field == `GPT_MODE_ONE_SHOT) begin
            timer_control_reg.low_enable_bit <= 1'b0;
        end else if (ctl_write) begin
            timer_control_reg <= ctl_wdata;
        end
    end

    // Interval load registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_interval_load <= `GPT_HALF_RESET;
            high_interval_load <= `GPT_HALF_RESET;
        end else if (load_write) begin
            high_interval_load <= load_wdata[31:16];
            low_interval_load <= load_wdata[15:0];
        end
    end

    // Match value of clock mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_match_reg <= `GPT_MATCH_RESET;
        end else if (match_write) begin
            low_match_reg <= match_wdata;
        end
    end

    // Prescale values are only kept: the 32-bit modes do not divide by them
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_prescale_reg <= `GPT_PRESCALE_RESET;
            high_prescale_reg <= `GPT_PRESCALE_RESET;
        end else begin
            if (low_prescale_write) begin
                low_prescale_reg <= prescale_wdata;
            end
            if (high_prescale_write) begin
                high_prescale_reg <= prescale_wdata;
            end
        end
    end

    // A load rewrite while counting down is applied one cycle later
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_reload <= 1'b0;
        end else begin
            pending_reload <= load_write && state == ST_DOWN;
        end
    end

    // Seeding happens once each time clock mode is selected
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clock_seeded <= 1'b0;
        end else if (!joined_clock) begin
            clock_seeded <= 1'b0;
        end else begin
            clock_seeded <= 1'b1;
        end
    end

    // The joined 32-bit counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {high_half, low_half} <= {`GPT_HALF_RESET, `GPT_HALF_RESET};
        end else if (joined_clock && !clock_seeded) begin
            {high_half, low_half} <= `GPT_CLOCK_MODE_START;
        end else if (joined_clock && match_write && !timer_control_reg.low_enable_bit) begin
            {high_half, low_half} <= match_wdata;
        end else if (pending_reload) begin
            {high_half, low_half} <= joined_load;
        end else if (state == ST_IDLE && joined_down && !timer_control_reg.low_enable_bit && load_write) begin
            {high_half, low_half} <= load_wdata;
        end else if (zero_hit) begin
            {high_half, low_half} <= joined_load;
        end else if (state == ST_DOWN && count_go) begin
            {high_half, low_half} <= joined_count - 32'h0000_0001;
        end else if (clock_hit) begin
            {high_half, low_half} <= 32'h0000_0000;
        end else if (state == ST_CLOCK && second_tick) begin
            {high_half, low_half} <= joined_count + 32'h0000_0001;
        end
    end

    // Sticky flags: an event in the clear cycle wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            raw_irq_status_reg <= '0;
        end else begin
            raw_irq_status_reg.timeout_raw_flag <= zero_hit ||
                (raw_irq_status_reg.timeout_raw_flag && !irq_clear_reg.timeout_raw_flag);
            raw_irq_status_reg.clock_match_raw_flag <= clock_hit ||
                (raw_irq_status_reg.clock_match_raw_flag && !irq_clear_reg.clock_match_raw_flag);
        end
    end

    irq_flags_t next_raw;
    always_comb begin
        next_raw.timeout_raw_flag = zero_hit ||
            (raw_irq_status_reg.timeout_raw_flag && !irq_clear_reg.timeout_raw_flag);
        next_raw.clock_match_raw_flag = clock_hit ||
            (raw_irq_status_reg.clock_match_raw_flag && !irq_clear_reg.clock_match_raw_flag);
    end

    // Masked flags follow the raw flags in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            masked_irq_status_reg <= '0;
        end else begin
            masked_irq_status_reg <= next_raw & irq_mask_reg;
        end
    end

    // Interrupt line stays high while any unmasked flag stands
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= |(next_raw & irq_mask_reg);
        end
    end

    // Trigger of the other units is ORed with the own timeout pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            adc_trigger_out <= 1'b0;
        end else begin
            adc_trigger_out <= adc_trigger_in |
                (zero_hit & timer_control_reg.low_adc_trigger_enable);
        end
    end

    // Count read joins both halves, one cycle behind the counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_count_value <= {`GPT_HALF_RESET, `GPT_HALF_RESET};
        end else begin
            low_count_value <= join_halves(high_half, low_half);
        end
    end

    // Joined load as software reads it back
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            load_value <= {`GPT_HALF_RESET, `GPT_HALF_RESET};
        end else begin
            load_value <= joined_load;
        end
    end

    // Copy of the match register for software
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            match_value <= `GPT_MATCH_RESET;
        end else begin
            match_value <= low_match_reg;
        end
    end
endmodule // gp_timer_unit

// file: testbench/gp_timer_props.sv
// Concurrent checks on the ports of the timer unit
module gp_timer_props
    import gp_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Inputs
    input wire logic [2:0] timer_config_reg,
    input wire logic load_write,
    input wire logic [31:0] load_wdata,
    input wire logic low_prescale_write,
    input wire logic [7:0] prescale_wdata,
    input wire irq_flags_t irq_clear_reg,
    input wire logic debug_halt,
    input wire logic adc_trigger_in,
    // Outputs
    input wire timer_control_t timer_control_reg,
    input wire logic [31:0] low_count_value,
    input wire logic [31:0] load_value,
    input wire logic [7:0] low_prescale_reg,
    input wire irq_flags_t raw_irq_status_reg,
    input wire irq_flags_t masked_irq_status_reg,
    input wire logic timer_irq,
    input wire logic adc_trigger_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_trig_chain_or: assert property ($past(adc_trigger_in) |-> adc_trigger_out)
        else $error("trigger from chain lost");
    a_load_split: assert property ($past(load_write, 2) |-> load_value == $past(load_wdata, 2))
        else $error("load not taken");
    a_prescale_store: assert property ($past(low_prescale_write) |-> low_prescale_reg == $past(prescale_wdata))
        else $error("prescale not stored");
    a_timeout_sticky: assert property ($past(raw_irq_status_reg.timeout_raw_flag)
        && !$past(irq_clear_reg.timeout_raw_flag) |-> raw_irq_status_reg.timeout_raw_flag)
        else $error("timeout flag dropped");
    a_match_sticky: assert property ($past(raw_irq_status_reg.clock_match_raw_flag)
        && !$past(irq_clear_reg.clock_match_raw_flag) |-> raw_irq_status_reg.clock_match_raw_flag)
        else $error("match flag dropped");
    a_masked_needs_raw: assert property (masked_irq_status_reg.timeout_raw_flag |->
        raw_irq_status_reg.timeout_raw_flag) else $error("masked without raw");
    a_irq_has_cause: assert property (timer_irq |-> (|raw_irq_status_reg) || $past(|raw_irq_status_reg))
        else $error("irq without flag");
    a_halt_freeze: assert property (timer_config_reg == 3'h0 && timer_control_reg.low_debug_stall_bit
        && debug_halt && $past(debug_halt) |=> $stable(low_count_value)) else $error("count moved in halt");
    c_timeout: cover property ($rose(raw_irq_status_reg.timeout_raw_flag));
    c_match: cover property ($rose(raw_irq_status_reg.clock_match_raw_flag));
    c_trigger: cover property (adc_trigger_out);
endmodule // gp_timer_props

// file: testbench/testbench.sv
// Self-checking testbench of the timer unit
module testbench
    import gp_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, ctl_write, load_write, match_write, low_prescale_write, high_prescale_write;
    logic debug_halt, adc_trigger_in, capture_compare_pin;
    logic [2:0] timer_config_reg;
    logic [1:0] low_mode_field, high_mode_field;
    logic [31:0] load_wdata, match_wdata, low_count_value, load_value, match_value, v;
    logic [7:0] prescale_wdata, low_prescale_reg, high_prescale_reg;
    timer_control_t ctl_wdata, timer_control_reg;
    irq_flags_t irq_mask_reg, irq_clear_reg, raw_irq_status_reg, masked_irq_status_reg;
    logic timer_irq, adc_trigger_out;
    int err_total, num_checks, trig_n, trig_base;

    gp_timer_unit #(.RTC_DIVIDE(2)) gp_timer_unit_inst (.clk, .arst_n, .timer_config_reg, .low_mode_field,
        .high_mode_field, .ctl_write, .ctl_wdata, .load_write, .load_wdata, .match_write, .match_wdata,
        .low_prescale_write, .high_prescale_write, .prescale_wdata, .irq_mask_reg, .irq_clear_reg, .debug_halt,
        .adc_trigger_in, .capture_compare_pin, .timer_control_reg, .low_count_value, .load_value, .match_value,
        .low_prescale_reg, .high_prescale_reg, .raw_irq_status_reg, .masked_irq_status_reg, .timer_irq,
        .adc_trigger_out);

    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // Free-running 32.768 kHz oscillator
    initial begin
        capture_compare_pin = 0;
        forever #15258.789 capture_compare_pin = ~capture_compare_pin;
    end
    always @(posedge clk) trig_n <= !arst_n ? 0 : trig_n + int'(adc_trigger_out === 1'b1);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic ctl(input logic en, input logic stall, input logic trig, input logic rtc);
        @(negedge clk);
        ctl_wdata = '{en, stall, stall, trig, rtc};
        ctl_write = 1;
        @(negedge clk);
        ctl_write = 0;
    endtask

    // Kind 0 load, 1 match, 2 low prescale, 3 high prescale
    task automatic wr(input int k, input logic [31:0] d);
        @(negedge clk);
        load_wdata = d;
        match_wdata = d;
        prescale_wdata = d[7:0];
        {high_prescale_write, low_prescale_write, match_write, load_write} = 4'h1 << k;
        @(negedge clk);
        {high_prescale_write, low_prescale_write, match_write, load_write} = 4'h0;
        // Status copies of load and match settle one cycle after the write
        @(negedge clk);
    endtask

    task automatic clr(input irq_flags_t f);
        @(negedge clk);
        irq_clear_reg = f;
        @(negedge clk);
        irq_clear_reg = 2'h0;
        @(negedge clk);
    endtask

    task automatic wait_raw(input int b, input int lim);
        int n;
        n = 0;
        while (raw_irq_status_reg[b] !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        check(n < lim, 1);
        repeat (3) @(negedge clk);
    endtask

    initial begin
        #240000;
        err_total++;
        print_verdict();
    end

    initial begin
        {arst_n, ctl_write, load_write, match_write, low_prescale_write, high_prescale_write} = 6'h00;
        {debug_halt, adc_trigger_in, timer_config_reg, low_mode_field, high_mode_field} = 9'h000;
        {load_wdata, match_wdata, prescale_wdata, ctl_wdata} = 77'h0;
        {irq_mask_reg, irq_clear_reg} = 4'h0;
        err_total = 0;
        num_checks = 0;
        trig_base = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        arst_n = 1;
        check(load_value, 32'hFFFF_FFFF);
        check(low_count_value, 32'hFFFF_FFFF);
        check({timer_control_reg, raw_irq_status_reg, masked_irq_status_reg, timer_irq}, 10'h000);
        check({low_prescale_reg, high_prescale_reg}, 16'h0000);
        wr(2, 8'h5A);
        wr(3, 8'hA5);
        check({low_prescale_reg, high_prescale_reg}, 16'h5AA5);
        adc_trigger_in = 1;
        @(negedge clk);
        adc_trigger_in = 0;
        repeat (2) @(negedge clk);
        check(trig_n, 1);
        // One-shot with trigger and unmasked timeout
        low_mode_field = 2'h1;
        high_mode_field = 2'h2;
        irq_mask_reg = 2'h1;
        wr(0, 32'h1234_5678);
        check(load_value, 32'h1234_5678);
        wr(1, 32'h0000_0002);
        check(match_value, 32'h0000_0002);
        wr(0, 32'h0000_0006);
        @(negedge clk);
        check(low_count_value, 32'h0000_0006);
        trig_base = trig_n;
        ctl(1, 0, 1, 0);
        wait_raw(0, 40);
        check(timer_control_reg.low_enable_bit, 0);
        check(low_count_value, 32'h0000_0006);
        check({masked_irq_status_reg.timeout_raw_flag, timer_irq}, 2'h3);
        check(trig_n - trig_base, 1);
        repeat (5) @(negedge clk);
        check(raw_irq_status_reg.timeout_raw_flag, 1);
        clr(2'h1);
        check({raw_irq_status_reg, timer_irq}, 3'h0);
        // Periodic from the low field alone, masked, no trigger
        low_mode_field = 2'h2;
        high_mode_field = 2'h1;
        irq_mask_reg = 2'h0;
        trig_base = trig_n;
        ctl(1, 0, 0, 0);
        wait_raw(0, 40);
        check(timer_control_reg.low_enable_bit, 1);
        check({masked_irq_status_reg, timer_irq}, 3'h0);
        check(trig_n - trig_base, 0);
        wr(0, 32'h0000_0100);
        @(negedge clk);
        check(low_count_value > 32'hF0 && low_count_value <= 32'h100, 1);
        ctl(1, 1, 0, 0);
        debug_halt = 1;
        repeat (3) @(negedge clk);
        v = low_count_value;
        repeat (5) @(negedge clk);
        check(low_count_value, v);
        debug_halt = 0;
        repeat (3) @(negedge clk);
        check(low_count_value != v, 1);
        ctl(0, 0, 0, 0);
        clr(2'h1);
        // Clock mode counts up through a debug halt
        timer_config_reg = 3'h1;
        repeat (3) @(negedge clk);
        check(low_count_value, 32'h0000_0001);
        irq_mask_reg = 2'h2;
        debug_halt = 1;
        ctl(1, 1, 0, 1);
        // First tick needs two pin rises, so it cannot come within the first pin period
        v = 0;
        while (low_count_value !== 32'h0000_0002 && v < 32'd20000) begin
            @(negedge clk);
            v++;
        end
        check(v > 32'd6000 && v < 32'd20000, 1);
        check(low_count_value, 32'h0000_0002);
        wait_raw(1, 30000);
        check(low_count_value, 32'h0000_0000);
        check({masked_irq_status_reg.clock_match_raw_flag, timer_irq}, 2'h3);
        clr(2'h2);
        check({raw_irq_status_reg, masked_irq_status_reg}, 4'h0);
        // Any other configuration keeps the counter still
        timer_config_reg = 3'h4;
        ctl(1, 0, 0, 0);
        repeat (8) @(negedge clk);
        check(low_count_value, 32'h0000_0000);
        check(raw_irq_status_reg, 2'h0);
        print_verdict();
    end
endmodule // testbench

bind gp_timer_unit gp_timer_props gp_timer_props_inst (.clk, .arst_n, .timer_config_reg, .load_write, .load_wdata,
    .low_prescale_write, .prescale_wdata, .irq_clear_reg, .debug_halt, .adc_trigger_in, .timer_control_reg,
    .low_count_value, .load_value, .low_prescale_reg, .raw_irq_status_reg, .masked_irq_status_reg, .timer_irq,
    .adc_trigger_out);
